// [gate_fault_pkg.sv]
// Overview of operation
// - Summary bit 7 ORs every fault flag; warning only when routed
// - Bit 6 ORs driver supply, regulator flags
// - Bit 5 ORs charge pump, motor supply
// - Bit 4 ORs six drain-source overcurrents
// - Bit 3 ORs six gate voltage errors
// - Bit 2 ORs three shunt overcurrents
// - Bit 1 thermal shutdown, bit 0 warning
// - Clear command or long enable low clears
// - Supply status bits 7..2, bits 1..0 zero
// - Phase A high nibble, phase B low
// - Phase C bits 7..4, bit 3 zero
// - Bits 2..0 flag shunt channels 1..3
// - Control bits 7..2 make supply faults report-only
// - Control bit 1 makes thermal shutdown report-only
// - Control bit 0 routes warning to pin
// - Status read-only zero; control read-write zero
// - Clear bit self-returns to zero
// - Sleep resets every register; long enable low keeps control
package gate_fault_pkg;

	// Register addresses on the serial port
	localparam logic [6:0] ADDR_SUMMARY = 7'h00;
	localparam logic [6:0] ADDR_SUPPLY = 7'h01;
	localparam logic [6:0] ADDR_PHASE_AB = 7'h02;
	localparam logic [6:0] ADDR_PHASE_C = 7'h03;
	localparam logic [6:0] ADDR_REPORT_CTL = 7'h04;
	localparam logic [6:0] ADDR_CLEAR_CMD = 7'h06;

	// Reset and read-back values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam int CLEAR_BIT = 7;

	// Serial frame layout: read flag, 7 address bits, 8 data bits
	localparam int FRAME_BITS = 16;
	localparam int HEADER_BITS = 8;
	localparam logic READ_FLAG = 1'b1;

	// Enable-low recovery time
	localparam int CLK_PERIOD_NS = 20;
	localparam int EN_LOW_TIME_NS = 850000;
	localparam int EN_LOW_CYCLES_DEF = (EN_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Supply related fault set, in status and control bit order
	typedef struct packed {
		logic driver_supply_low_flag;
		logic driver_supply_high_flag;
		logic regulator_overcurrent_flag;
		logic charge_pump_low_flag;
		logic motor_supply_low_flag;
		logic motor_supply_high_flag;
	} supply_fault_t;

	// Per phase fault set
	typedef struct packed {
		logic high_ds_overcurrent;
		logic low_ds_overcurrent;
		logic high_gate_error;
		logic low_gate_error;
	} phase_fault_t;

	// All detector events, also the sticky flag store
	typedef struct packed {
		supply_fault_t supply;
		phase_fault_t phase_a;
		phase_fault_t phase_b;
		phase_fault_t phase_c;
		logic shunt1_overcurrent_flag;
		logic shunt2_overcurrent_flag;
		logic shunt3_overcurrent_flag;
		logic thermal_shutdown_flag;
		logic thermal_warning_flag;
	} fault_events_t;

	// Summary status byte
	typedef struct packed {
		logic any_fault;
		logic regulator_error_summary;
		logic supply_voltage_summary;
		logic drain_source_overcurrent_summary;
		logic gate_voltage_error_summary;
		logic shunt_overcurrent_summary;
		logic thermal_shutdown_flag;
		logic thermal_warning_flag;
	} summary_status_t;

	// Supply status byte
	typedef struct packed {
		supply_fault_t supply;
		logic [1:0] unassigned;
	} supply_status_t;

	// Phase C and shunt status byte
	typedef struct packed {
		phase_fault_t phase_c;
		logic unassigned;
		logic shunt1_overcurrent_flag;
		logic shunt2_overcurrent_flag;
		logic shunt3_overcurrent_flag;
	} phase_c_status_t;

	// Fault report control byte
	typedef struct packed {
		logic driver_low_report_only;
		logic driver_high_report_only;
		logic regulator_overcurrent_report_only;
		logic charge_pump_low_report_only;
		logic motor_supply_low_report_only;
		logic motor_supply_high_report_only;
		logic thermal_shutdown_report_only;
		logic thermal_warning_pin_route;
	} report_ctl_t;

	// Serial port states
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_SHIFT = 1'b1
	} port_state_t;

endpackage : gate_fault_pkg

// [sync_two_flop.sv]
`timescale 1ns/10ps
module sync_two_flop #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Asynchronous input and synchronised output
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_r;

	// First stage feeds only the second, to keep metastability contained
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stage1_r <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1_r <= async_in;
			sync_out <= stage1_r;
		end
	end

endmodule : sync_two_flop

// [gate_driver_fault_status_bank.sv]
`timescale 1ns/10ps
module gate_driver_fault_status_bank #(
	parameter int EN_LOW_CYCLES = gate_fault_pkg::EN_LOW_CYCLES_DEF
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Enable pin and power mode
	input wire logic enable_pin,
	input wire logic sleep_mode,
	// Raw detector events
	input wire gate_fault_pkg::fault_events_t fault_events,
	// Serial register port
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	output logic spi_miso_out,
	output logic spi_miso_oe,
	// Fault pin and protective actions
	output logic error_indicator_pin_n,
	output gate_fault_pkg::supply_fault_t supply_trip,
	output logic thermal_trip
);

	localparam int EV_W = $bits(gate_fault_pkg::fault_events_t);
	localparam int SYNC_W = EV_W + 4;
	localparam int CNT_W = $clog2(EN_LOW_CYCLES + 1);

	logic [SYNC_W-1:0] sync_q;
	gate_fault_pkg::fault_events_t ev_s;
	logic en_s;
	logic cs_n_s;
	logic sclk_s;
	logic mosi_s;
	gate_fault_pkg::fault_events_t flags_r;
	gate_fault_pkg::report_ctl_t ctl_r;
	gate_fault_pkg::summary_status_t summary;
	gate_fault_pkg::supply_status_t supply_stat;
	gate_fault_pkg::phase_c_status_t phase_c_stat;
	logic [7:0] phase_ab_stat;
	logic [CNT_W-1:0] en_low_cnt_r;
	logic en_long_low;
	logic clear_cmd_r;
	logic clear_any;
	gate_fault_pkg::port_state_t state_r;
	logic sclk_prev_r;
	logic sclk_rise;
	logic sclk_fall;
	logic port_active;
	logic [4:0] bit_cnt_r;
	logic [gate_fault_pkg::FRAME_BITS-2:0] rx_r;
	logic [7:0] tx_r;
	logic header_done;
	logic frame_done;
	logic [6:0] hdr_addr;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_strobe;

	// All pins and detector lines cross into ref_clk here
	sync_two_flop #(
		.WIDTH(SYNC_W)
	) u_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.async_in({enable_pin, spi_cs_n, spi_sclk, spi_mosi, fault_events}),
		.sync_out(sync_q)
	);

	// Split synchronised bundle
	assign en_s = sync_q[SYNC_W-1];
	assign cs_n_s = sync_q[SYNC_W-2];
	assign sclk_s = sync_q[SYNC_W-3];
	assign mosi_s = sync_q[SYNC_W-4];
	assign ev_s = gate_fault_pkg::fault_events_t'(sync_q[EV_W-1:0]);

	// Register read decode, used for every read frame
	function automatic logic [7:0] read_reg(input logic [6:0] addr,
		input gate_fault_pkg::summary_status_t s0,
		input gate_fault_pkg::supply_status_t s1,
		input logic [7:0] s2,
		input gate_fault_pkg::phase_c_status_t s3,
		input gate_fault_pkg::report_ctl_t c);
		logic [7:0] val;
		val = gate_fault_pkg::UNMAPPED_READ;
		if (addr == gate_fault_pkg::ADDR_SUMMARY)
			val = s0;
		else if (addr == gate_fault_pkg::ADDR_SUPPLY)
			val = s1;
		else if (addr == gate_fault_pkg::ADDR_PHASE_AB)
			val = s2;
		else if (addr == gate_fault_pkg::ADDR_PHASE_C)
			val = s3;
		else if (addr == gate_fault_pkg::ADDR_REPORT_CTL)
			val = c;
		// Clear command register always reads back as zero
		else if (addr == gate_fault_pkg::ADDR_CLEAR_CMD)
			val = gate_fault_pkg::REG_RESET;
		return val;
	endfunction : read_reg

	// Long enable-low detector; saturates so the clear holds while low
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			en_low_cnt_r <= '0;
		else if (en_s)
			en_low_cnt_r <= '0;
		else if (en_low_cnt_r != CNT_W'(EN_LOW_CYCLES))
			en_low_cnt_r <= en_low_cnt_r + CNT_W'(1);
	end

	assign en_long_low = !en_s && (en_low_cnt_r == CNT_W'(EN_LOW_CYCLES));
	assign clear_any = clear_cmd_r | en_long_low | sleep_mode;

	// Sticky flags; a new event wins over a clear in the same cycle
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			flags_r <= '0;
		else
			flags_r <= gate_fault_pkg::fault_events_t'((flags_r & ~{EV_W{clear_any}}) | ev_s);
	end

	// Summary byte built from the flag store
	always_comb
	begin
		summary.regulator_error_summary = flags_r.supply.driver_supply_low_flag
			| flags_r.supply.driver_supply_high_flag
			| flags_r.supply.regulator_overcurrent_flag;
		summary.supply_voltage_summary = flags_r.supply.charge_pump_low_flag
			| flags_r.supply.motor_supply_low_flag
			| flags_r.supply.motor_supply_high_flag;
		summary.drain_source_overcurrent_summary = flags_r.phase_a.high_ds_overcurrent
			| flags_r.phase_a.low_ds_overcurrent | flags_r.phase_b.high_ds_overcurrent
			| flags_r.phase_b.low_ds_overcurrent | flags_r.phase_c.high_ds_overcurrent
			| flags_r.phase_c.low_ds_overcurrent;
		summary.gate_voltage_error_summary = flags_r.phase_a.high_gate_error
			| flags_r.phase_a.low_gate_error | flags_r.phase_b.high_gate_error
			| flags_r.phase_b.low_gate_error | flags_r.phase_c.high_gate_error
			| flags_r.phase_c.low_gate_error;
		summary.shunt_overcurrent_summary = flags_r.shunt1_overcurrent_flag
			| flags_r.shunt2_overcurrent_flag | flags_r.shunt3_overcurrent_flag;
		summary.thermal_shutdown_flag = flags_r.thermal_shutdown_flag;
		summary.thermal_warning_flag = flags_r.thermal_warning_flag;
		// overall fault; warning counts only when routed
		summary.any_fault = summary.regulator_error_summary
			| summary.supply_voltage_summary
			| summary.drain_source_overcurrent_summary
			| summary.gate_voltage_error_summary
			| summary.shunt_overcurrent_summary
			| summary.thermal_shutdown_flag
			| (summary.thermal_warning_flag & ctl_r.thermal_warning_pin_route);
	end

	// Detail status bytes
	always_comb
	begin
		supply_stat.supply = flags_r.supply;
		supply_stat.unassigned = '0;
		phase_ab_stat = {flags_r.phase_a, flags_r.phase_b};
		phase_c_stat.phase_c = flags_r.phase_c;
		phase_c_stat.unassigned = 1'b0;
		phase_c_stat.shunt1_overcurrent_flag = flags_r.shunt1_overcurrent_flag;
		phase_c_stat.shunt2_overcurrent_flag = flags_r.shunt2_overcurrent_flag;
		phase_c_stat.shunt3_overcurrent_flag = flags_r.shunt3_overcurrent_flag;
	end

	// Fault pin and protective actions, registered to keep them glitch free
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			error_indicator_pin_n <= 1'b1;
			supply_trip <= '0;
			thermal_trip <= 1'b0;
		end
		else
		begin
			error_indicator_pin_n <= ~summary.any_fault;
			supply_trip <= flags_r.supply & ~ctl_r[7:2];
			thermal_trip <= flags_r.thermal_shutdown_flag & ~ctl_r.thermal_shutdown_report_only;
		end
	end

	// Serial clock edges, found from the synchronised copy
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			sclk_prev_r <= 1'b0;
		else
			sclk_prev_r <= sclk_s;
	end

	assign sclk_rise = sclk_s & ~sclk_prev_r;
	assign sclk_fall = ~sclk_s & sclk_prev_r;
	assign port_active = !cs_n_s && en_s;

	// Frame state; a chip select rise mid-frame aborts without effect
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			state_r <= gate_fault_pkg::ST_IDLE;
		else
		begin
			case (state_r)
				gate_fault_pkg::ST_IDLE:
					if (port_active)
						state_r <= gate_fault_pkg::ST_SHIFT;
				gate_fault_pkg::ST_SHIFT:
					if (!port_active)
						state_r <= gate_fault_pkg::ST_IDLE;
				default:
					state_r <= gate_fault_pkg::ST_IDLE;
			endcase
		end
	end

	// Frame decode points
	assign header_done = (state_r == gate_fault_pkg::ST_SHIFT) && sclk_rise
		&& (bit_cnt_r == 5'(gate_fault_pkg::HEADER_BITS - 1));
	assign frame_done = (state_r == gate_fault_pkg::ST_SHIFT) && sclk_rise
		&& (bit_cnt_r == 5'(gate_fault_pkg::FRAME_BITS - 1));
	assign hdr_addr = {rx_r[5:0], mosi_s};
	assign wr_addr = rx_r[13:7];
	assign wr_data = {rx_r[6:0], mosi_s};
	assign wr_strobe = frame_done && (rx_r[14] != gate_fault_pkg::READ_FLAG);

	// Receive shifter, sampled on rising serial clock
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bit_cnt_r <= '0;
			rx_r <= '0;
		end
		else if (state_r == gate_fault_pkg::ST_IDLE)
		begin
			bit_cnt_r <= '0;
			rx_r <= '0;
		end
		else if (sclk_rise && bit_cnt_r != 5'(gate_fault_pkg::FRAME_BITS))
		begin
			bit_cnt_r <= bit_cnt_r + 5'd1;
			rx_r <= {rx_r[gate_fault_pkg::FRAME_BITS-3:0], mosi_s};
		end
	end

	// Transmit shifter; read data is captured once the header is in
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			tx_r <= '0;
		else if (state_r == gate_fault_pkg::ST_IDLE)
			tx_r <= '0;
		else if (header_done && rx_r[6] == gate_fault_pkg::READ_FLAG)
			tx_r <= read_reg(hdr_addr, summary, supply_stat, phase_ab_stat, phase_c_stat, ctl_r);
		else if (sclk_fall && bit_cnt_r > 5'(gate_fault_pkg::HEADER_BITS))
			tx_r <= {tx_r[6:0], 1'b0};
	end

	// Data line is driven only inside a frame
	assign spi_miso_out = tx_r[7];
	assign spi_miso_oe = (state_r == gate_fault_pkg::ST_SHIFT);

	// Report control register
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			ctl_r <= gate_fault_pkg::REG_RESET;
		else if (sleep_mode)
			ctl_r <= gate_fault_pkg::REG_RESET;
		else if (wr_strobe && wr_addr == gate_fault_pkg::ADDR_REPORT_CTL)
			ctl_r <= wr_data;
	end

	// Clear command, one cycle long and never stored
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			clear_cmd_r <= 1'b0;
		else
			clear_cmd_r <= wr_strobe && (wr_addr == gate_fault_pkg::ADDR_CLEAR_CMD)
				&& wr_data[gate_fault_pkg::CLEAR_BIT];
	end

endmodule : gate_driver_fault_status_bank

// [gate_fault_sva.sv]
`timescale 1ns/10ps
module gate_fault_sva #(
	parameter int EN_LOW_CYCLES = gate_fault_pkg::EN_LOW_CYCLES_DEF
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Watched inputs
	input wire logic enable_pin,
	input wire logic sleep_mode,
	input wire gate_fault_pkg::fault_events_t fault_events,
	input wire logic spi_cs_n,
	// Watched outputs
	input wire logic spi_miso_oe,
	input wire logic error_indicator_pin_n,
	input wire gate_fault_pkg::supply_fault_t supply_trip,
	input wire logic thermal_trip
);
	int hi_cnt_r;
	int lo_cnt_r;

	// Saturating run lengths; the synchronisers lag the raw pins, so margins are kept
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hi_cnt_r <= 0;
			lo_cnt_r <= 0;
		end
		else
		begin
			hi_cnt_r <= !enable_pin ? 0 : (hi_cnt_r < 8) ? hi_cnt_r + 1 : 8;
			lo_cnt_r <= (enable_pin || fault_events != '0) ? 0 :
				(lo_cnt_r < EN_LOW_CYCLES + 6) ? lo_cnt_r + 1 : lo_cnt_r;
		end
	end

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	reset_values_a: assert property (
		$rose(rst_b) |-> error_indicator_pin_n && !thermal_trip && supply_trip == '0 && !spi_miso_oe)
		else $error("outputs not idle after reset");
	fault_pin_a: assert property (
		(fault_events[22:1] != '0) [*3] |-> ##[1:6] !error_indicator_pin_n)
		else $error("fault pin missed a fault");
	flag_sticky_a: assert property (
		!error_indicator_pin_n && hi_cnt_r == 8 && spi_cs_n && $past(spi_cs_n, 4) && !sleep_mode
		&& !$past(sleep_mode) && !$past(sleep_mode, 2) |=> !error_indicator_pin_n)
		else $error("fault flag dropped without a clear");
	sleep_clear_a: assert property (
		(sleep_mode && fault_events == '0) [*6] |-> error_indicator_pin_n && !thermal_trip)
		else $error("sleep left a flag set");
	enable_clear_a: assert property (
		lo_cnt_r == EN_LOW_CYCLES + 6 |-> error_indicator_pin_n && supply_trip == '0)
		else $error("long enable low left a flag set");
	supply_trip_a: assert property (
		supply_trip != '0 |-> ##[0:1] !error_indicator_pin_n)
		else $error("supply trip without fault pin");
	thermal_trip_a: assert property (
		thermal_trip |-> ##[0:1] !error_indicator_pin_n)
		else $error("thermal trip without fault pin");
	refused_frame_a: assert property (
		(!enable_pin) [*8] |-> !spi_miso_oe)
		else $error("frame opened with enable low");
	frame_open_a: assert property (
		$fell(spi_cs_n) && hi_cnt_r == 8 |-> ##[2:5] spi_miso_oe)
		else $error("frame did not open");

	cover property (!error_indicator_pin_n);
	cover property (thermal_trip);
	cover property (supply_trip != '0);
endmodule : gate_fault_sva

// [spi_host_model.sv]
`timescale 1ns/10ps
module spi_host_model (
	// Clock
	input wire logic ref_clk,
	// Serial port pins
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_mosi,
	input wire logic spi_miso
);
	// Idle: deselected, clock low
	initial
	begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_mosi = 1'b0;
	end

	// host frame, mode 0
	// Four ref_clk per phase gives an 80 ns phase, 160 ns period; data sampled late in the high phase
	task automatic xfer(input logic [15:0] frm, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge ref_clk);
		spi_cs_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		for (int i = 15; i >= 0; i--)
		begin
			spi_mosi <= frm[i];
			repeat (4) @(posedge ref_clk);
			spi_sclk <= 1'b1;
			repeat (3) @(posedge ref_clk);
			@(negedge ref_clk);
			rd = {rd[6:0], spi_miso};
			@(posedge ref_clk);
			spi_sclk <= 1'b0;
		end
		repeat (4) @(posedge ref_clk);
		spi_cs_n <= 1'b1;
		// Released data line shows no stale bit
		spi_mosi <= ~frm[0];
		repeat (6) @(posedge ref_clk);
	endtask : xfer
endmodule : spi_host_model

// [gate_driver_fault_status_bank_bench.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module gate_driver_fault_status_bank_bench;
	localparam int EN_LOW = 20;
	logic ref_clk;
	logic rst_b;
	logic enable_pin;
	logic sleep_mode;
	gate_fault_pkg::fault_events_t ev;
	logic spi_cs_n;
	logic spi_sclk;
	logic spi_mosi;
	logic spi_miso_out;
	logic spi_miso_oe;
	wire miso_w;
	logic error_indicator_pin_n;
	gate_fault_pkg::supply_fault_t supply_trip;
	logic thermal_trip;
	int n_errors;
	int checked;
	int cyc;
	logic [31:0] rng;
	logic [22:0] f;
	logic [7:0] ctl;
	logic [7:0] rd;
	logic [7:0] seen;
	logic [7:0] e_m;
	string n_m;
	logic [7:0] ex[5];
	logic [7:0] exp_q[$];
	string nm_q[$];
	event seen_ev;

	gate_driver_fault_status_bank #(.EN_LOW_CYCLES(EN_LOW)) DUT (
		.ref_clk(ref_clk), .rst_b(rst_b), .enable_pin(enable_pin), .sleep_mode(sleep_mode),
		.fault_events(ev), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
		.spi_miso_out(spi_miso_out), .spi_miso_oe(spi_miso_oe),
		.error_indicator_pin_n(error_indicator_pin_n), .supply_trip(supply_trip),
		.thermal_trip(thermal_trip));
	spi_host_model host (.ref_clk(ref_clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
		.spi_mosi(spi_mosi), .spi_miso(miso_w));

	// Released data line shows the inverse, so a read outside a frame cannot match
	assign miso_w = spi_miso_oe ? spi_miso_out : ~spi_miso_out;

	// 50 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift

	task automatic model(input logic [22:0] g, input logic [7:0] c);
		ex[0][6:0] = {|g[22:20], |g[19:17], |{g[16:15], g[12:11], g[8:7]},
			|{g[14:13], g[10:9], g[6:5]}, |g[4:2], g[1], g[0]};
		ex[0][7] = |ex[0][6:1] | (g[0] & c[0]);
		ex[1] = {g[22:17], 2'b00};
		ex[2] = g[16:9];
		ex[3] = {g[8:5], 1'b0, g[4:2]};
		ex[4] = c;
	endtask : model

	// Each driver notes its expectation before the result shows
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		nm_q.push_back($sformatf("reg %h", a));
		host.xfer({1'b1, a, 8'h00}, rd);
		seen = rd;
		->seen_ev;
	endtask : rd_chk
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer({1'b0, a, d}, rd);
	endtask : wr
	// Pin bundle: fault pin, thermal trip, supply trips
	task automatic pin_chk(input logic [7:0] e);
		exp_q.push_back(e);
		nm_q.push_back("pins");
		@(negedge ref_clk);
		seen = {error_indicator_pin_n, thermal_trip, supply_trip};
		->seen_ev;
	endtask : pin_chk

	// Scoreboard takes the oldest note for every result
	always @(seen_ev)
	begin
		e_m = exp_q.pop_front();
		n_m = nm_q.pop_front();
		`CHK(n_m, e_m, seen)
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	// Watchdog well above the roughly 41k cycles of traffic
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 90000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end

	// Main sequence
	initial
	begin
		rst_b = 1'b0;
		enable_pin = 1'b0;
		sleep_mode = 1'b0;
		ev = '0;
		n_errors = 0;
		checked = 0;
		cyc = 0;
		rng = 32'h0000_0047;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		enable_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		for (int a = 0; a < 8; a++)
			rd_chk(7'(a), 8'h00);
		$display("test reset values done");
		for (int k = 0; k < 30; k++)
		begin
			rng = xorshift(rng);
			ctl = rng[7:0];
			f = (k < 23) ? (23'h1 << k) : rng[30:8];
			wr(7'h04, ctl);
			ev <= f;
			repeat (3) @(posedge ref_clk);
			ev <= '0;
			enable_pin <= 1'b0;
			repeat (EN_LOW / 2) @(posedge ref_clk);
			enable_pin <= 1'b1;
			repeat (8) @(posedge ref_clk);
			model(f, ctl);
			pin_chk({~ex[0][7], f[1] & ~ctl[1], f[22:17] & ~ctl[7:2]});
			for (int a = 0; a < 5; a++)
				rd_chk(7'(a), ex[a]);
			if (k % 3 == 0)
			begin
				wr(7'h00, 8'hff);
				wr(7'h06, 8'h80);
			end
			else if (k % 3 == 1)
			begin
				enable_pin <= 1'b0;
				wr(7'h04, ~ctl);
				enable_pin <= 1'b1;
			end
			else
			begin
				sleep_mode <= 1'b1;
				repeat (8) @(posedge ref_clk);
				sleep_mode <= 1'b0;
				ctl = 8'h00;
			end
			repeat (8) @(posedge ref_clk);
			pin_chk(8'h80);
			rd_chk(7'h00, 8'h00);
			rd_chk(7'h04, ctl);
			$display("test %0d done", k);
		end
		// Let the scoreboard take the last note before the verdict
		@(posedge ref_clk);
		tally_and_finish();
	end
endmodule : gate_driver_fault_status_bank_bench

bind gate_driver_fault_status_bank gate_fault_sva #(.EN_LOW_CYCLES(EN_LOW_CYCLES)) chk (
	.ref_clk(ref_clk), .rst_b(rst_b), .enable_pin(enable_pin), .sleep_mode(sleep_mode),
	.fault_events(fault_events), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe),
	.error_indicator_pin_n(error_indicator_pin_n), .supply_trip(supply_trip),
	.thermal_trip(thermal_trip));
